/* File: rtl/gtlr_pkg.sv */
package gtlr_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [3:0] OFS_DATA = 4'h0;
  localparam logic [3:0] OFS_EVT1 = 4'h1;
  localparam logic [3:0] OFS_EVT2 = 4'h2;
  localparam logic [3:0] OFS_POLL = 4'h3;
  localparam logic [3:0] OFS_ADDR = 4'h4;
  localparam logic [3:0] OFS_AUX = 4'h5;
  localparam logic [3:0] OFS_DEVA = 4'h6;
  localparam logic [3:0] OFS_DEVB = 4'h7;
  localparam logic [3:0] OFS_CORE = 4'he;
  // ****************************************
  // Field positions, first event register
  // ****************************************
  localparam int B_UNK = 7;
  localparam int B_SEC = 6;
  localparam int B_TRG = 5;
  localparam int B_END = 4;
  localparam int B_CLR = 3;
  localparam int B_LOST = 2;
  localparam int B_OREQ = 1;
  localparam int B_IN = 0;
  // ****************************************
  // Field positions, second event register
  // ****************************************
  localparam int B_SUM = 7;
  localparam int B_LOK = 5;
  localparam int B_REM = 4;
  localparam int B_DMA_OUT_CONTROL = 5;
  localparam int B_DMA_IN_CONTROL = 4;
  localparam int B_LOCKOUT_CHANGE_FLAG = 2;
  localparam int B_REMOTE_CHANGE_FLAG = 1;
  localparam int B_ADDRESS_CHANGE_FLAG = 0;
  localparam logic [7:0] EVT2_MASK = 8'h07;
  // ****************************************
  // Poll, mode and address fields
  // ****************************************
  localparam int B_RSV = 6;
  localparam int B_TON = 7;
  localparam int B_LON = 6;
  localparam int B_ARS = 7;
  localparam int B_DT = 6;
  localparam int B_DL = 5;
  localparam int B_EOI = 7;
  localparam logic [1:0] MODE_ONE = 2'h1;
  localparam logic [1:0] MODE_TWO = 2'h2;
  localparam logic [1:0] MODE_THREE = 2'h3;
  // ****************************************
  // Reset values and fixed constants
  // ****************************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [6:0] RST_DEVA = 7'h00;
  // Arbitrary implementation constant
  localparam logic [7:0] CORE_CONST = 8'h10;
  localparam int FIFO_DEPTH = 4;
  localparam int DATA_W = 8;
endpackage

/* File: rtl/gtlr_regs.sv */
// What this block does
// RL1 - Listener bytes land in read register 0 and stay until next byte.
// RL2 - Host write to offset 0 loads a byte which is sent to the bus.
// RL3 - Reading an event status register returns flags and clears them.
// RL4 - Mask bit set enables interrupt for the matching status flag.
// RL5 - Summary bit is OR of unmasked flags and drives host interrupt.
// RL6 - With trapping on, unknown command sets flag and holds handshake until valid.
// RL7 - Mode 3 only: secondary address sets flag, holds handshake until valid/not valid.
// RL8 - GET while listener addressed sets trigger flag.
// RL9 - EOI byte or end-of-string match sets end flag.
// RL10 - DCL, or SDC while listener addressed, sets clear flag.
// RL11 - Byte sent without listener, or written in source idle, sets lost flag.
// RL12 - Output request when register free; input flag per byte except continuous mode.
// RL13 - Lockout/remote/address status changes set their change flags.
// RL14 - Lockout bit shows lockout states; remote bit shows remote states.
// RL15 - DMA-out requests while output free; DMA-in requests on received byte.
// RL16 - Status byte sent in poll, read back; service bit asserts request outside poll.
// RL17 - Pending bit sets with service bit, clears on poll acknowledge.
// RL18 - Mode bits: talk-only, listen-only, two-bit code; only modes ignore addresses.
// RL19 - Mode 1 recognises two primary addresses.
// RL20 - Mode 2 matches primary plus secondary, single primary only.
// RL21 - Mode 3: two primaries, secondaries handed to host to qualify.
// RL22 - Poll-active sets on enable, clears on disable or clear; second-match tracks address.
// RL23 - Offset 6 write loads address register 0 or 1 by select bit.
// RL24 - Address is talker if talker-disable 0, listener if listener-disable 0.
// RL25 - Top bit of offset 7 read shows EOI latched with current data byte.
// RL26 - Offset 0xE reads fixed constants; writes ignored.
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Small byte FIFO
// ****************************************
module gtlr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic [WIDTH-1:0] out_data_r;
  logic out_valid_r;
  wire do_wr = in_valid && in_ready;
  wire do_rd = out_valid && out_ready;
  // Head and valid are flopped so the transmit outputs carry no read mux
  wire [AW-1:0] rp_nxt = do_rd ? ((rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1) : rp_r;
  wire [AW:0] cnt_nxt = cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
  // A write into an empty or just emptied FIFO becomes the head at once
  wire head_new = do_wr && (cnt_r == (AW+1)'(do_rd));
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = out_valid_r;
  assign out_data = out_data_r;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      out_data_r <= '0;
      out_valid_r <= 1'b0;
    end else begin
      if (do_wr) wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      out_valid_r <= (cnt_nxt != '0);
      out_data_r <= head_new ? in_data : mem_r[rp_nxt];
    end
  end
  always_ff @(posedge mclk) begin
    if (do_wr) mem_r[wp_r] <= in_data;
  end
endmodule // gtlr_fifo

// ****************************************
// Register bank
// ****************************************
module gtlr_regs #(
  parameter int FDEPTH = 4
) (
  input wire logic mclk,
  input wire logic nrst,
  // Host register port
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic host_irq,
  output logic dma_req,
  // Receive side from the acceptor handshake
  input wire logic [7:0] rx_byte,
  input wire logic rx_eoi,
  input wire logic rx_strobe,
  output logic rx_holdoff,
  // Transmit side toward the source handshake
  output logic [7:0] tx_byte,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic tx_no_listener,
  input wire logic source_idle,
  // Bus and interface state inputs (already in mclk domain)
  input wire logic cmd_unknown,
  input wire logic cmd_secondary,
  input wire logic cmd_valid,
  input wire logic cmd_not_valid,
  input wire logic msg_get,
  input wire logic msg_dcl,
  input wire logic msg_sdc,
  input wire logic msg_spe,
  input wire logic msg_spd,
  input wire logic msg_ifc,
  input wire logic poll_active,
  input wire logic poll_ack,
  input wire logic lads,
  input wire logic rl_lock,
  input wire logic rl_remote,
  input wire logic addr_talk,
  input wire logic addr_listen,
  input wire logic addr_talker_primary_addressed,
  input wire logic addr_listener_primary_addressed,
  input wire logic addr_cic,
  input wire logic addr_first,
  input wire logic addr_second,
  input wire logic unknown_command_trap_enable,
  input wire logic continuous_mode,
  input wire logic eos_enable,
  input wire logic eos_8bit,
  // Decoded configuration for the addressing logic
  output logic talk_only,
  output logic listen_only,
  output logic [1:0] mode_code,
  output logic [6:0] dev_addr0,
  output logic [6:0] dev_addr1,
  output logic srq_assert,
  output logic [7:0] poll_byte
);
  import gtlr_pkg::*;

  logic [7:0] din_r;
  logic eoi_r;
  logic [7:0] flag1_r;
  logic [7:0] flag2_r;
  logic [7:0] mask1_r;
  logic [7:0] mask2_r;
  logic [7:0] poll_r;
  logic request_pending_bit_r;
  logic [7:0] amode_r;
  logic [6:0] adr0_r;
  logic [6:0] adr1_r;
  logic [7:0] eos_r;
  logic serial_poll_active_bit_r;
  logic second_address_match_bit_r;
  logic hold_r;
  logic hold_unk_r;
  logic unk_prev_r;
  logic lok_d_r;
  logic rem_d_r;
  logic [3:0] ads_d_r;
  logic [7:0] rdata_r;
  logic irq_r;
  logic dma_r;
  logic srq_r;

  // ****************************************
  // Decode
  // ****************************************
  wire rd_evt1 = reg_rd && (reg_addr == OFS_EVT1);
  wire rd_evt2 = reg_rd && (reg_addr == OFS_EVT2);
  wire wr_data = reg_wr && (reg_addr == OFS_DATA);
  wire wr_mask1 = reg_wr && (reg_addr == OFS_EVT1);
  wire wr_mask2 = reg_wr && (reg_addr == OFS_EVT2);
  wire wr_poll = reg_wr && (reg_addr == OFS_POLL);
  wire wr_mode = reg_wr && (reg_addr == OFS_ADDR);
  wire wr_adr = reg_wr && (reg_addr == OFS_DEVA);
  wire wr_eos = reg_wr && (reg_addr == OFS_DEVB);

  // Output FIFO decouples host writes from source handshake
  logic fifo_in_ready;
  gtlr_fifo #(.WIDTH(DATA_W), .DEPTH(FDEPTH)) u_fifo (
    .mclk(mclk),
    .nrst(nrst),
    .in_data(reg_wdata),
    .in_valid(wr_data && !source_idle), // RL2
    .in_ready(fifo_in_ready),
    .out_data(tx_byte),
    .out_valid(tx_valid),
    .out_ready(tx_ready)
  );

  wire tx_sent = tx_valid && tx_ready;
  wire eos_hit = eos_enable && (eos_8bit ? (rx_byte == eos_r) : (rx_byte[6:0] == eos_r[6:0]));
  wire [3:0] ads_now = {addr_talk, addr_listen, addr_cic, second_address_match_bit_r};
  // Any other primary message ends the run of commands after an unknown one
  wire prim_cmd = msg_get || msg_dcl || msg_sdc || msg_spe || msg_spd || msg_ifc
    || addr_first || addr_second;
  wire sec_unknown = cmd_secondary && unk_prev_r;

  // ****************************************
  // Event sources
  // ****************************************
  logic [7:0] ev1;
  logic [7:0] ev2;
  always_comb begin
    ev1 = '0;
    ev1[B_UNK] = unknown_command_trap_enable && (cmd_unknown || sec_unknown); // RL6
    ev1[B_SEC] = (amode_r[1:0] == MODE_THREE) && cmd_secondary && !unk_prev_r
      && !amode_r[B_TON] && !amode_r[B_LON]; // RL7 RL21
    ev1[B_TRG] = msg_get && lads; // RL8
    ev1[B_END] = rx_strobe && (rx_eoi || eos_hit); // RL9
    ev1[B_CLR] = msg_dcl || (msg_sdc && lads); // RL10
    ev1[B_LOST] = (tx_sent && tx_no_listener) || (wr_data && source_idle); // RL11
    ev1[B_OREQ] = fifo_in_ready; // RL12
    ev1[B_IN] = rx_strobe && !continuous_mode; // RL12
    ev2 = '0;
    ev2[B_LOCKOUT_CHANGE_FLAG] = (rl_lock != lok_d_r); // RL13
    ev2[B_REMOTE_CHANGE_FLAG] = (rl_remote != rem_d_r); // RL13
    ev2[B_ADDRESS_CHANGE_FLAG] = (ads_now != ads_d_r); // RL13
  end

  // Set beats the read-clear so an event in the read cycle survives
  wire [7:0] flag1_nxt = (rd_evt1 ? 8'h00 : flag1_r) | ev1; // RL3
  wire [7:0] flag2_nxt = ((rd_evt2 ? 8'h00 : flag2_r) | ev2) & EVT2_MASK; // RL3
  wire irq_nxt = |(flag1_nxt & mask1_r) || |(flag2_nxt & mask2_r & EVT2_MASK); // RL4 RL5
  wire serial_poll_active_bit_nxt = msg_spe ? 1'b1 : ((msg_spd || msg_ifc) ? 1'b0 : serial_poll_active_bit_r); // RL22
  wire second_address_match_bit_nxt = addr_second ? 1'b1 : (addr_first ? 1'b0 : second_address_match_bit_r); // RL22
  wire dma_nxt = (mask2_r[B_DMA_OUT_CONTROL] && fifo_in_ready)
    || (mask2_r[B_DMA_IN_CONTROL] && (rx_strobe || flag1_r[B_IN])); // RL15
  wire srq_nxt = poll_r[B_RSV] && !poll_active; // RL16
  wire rsv_rise = wr_poll && reg_wdata[B_RSV] && !poll_r[B_RSV];

  // ****************************************
  // Read mux
  // ****************************************
  logic [7:0] rmux;
  always_comb begin
    unique case (reg_addr)
      OFS_DATA: rmux = din_r; // RL1
      OFS_EVT1: rmux = flag1_r;
      OFS_EVT2: rmux = {irq_r, 1'b0, rl_lock, rl_remote, 1'b0, flag2_r[2:0]}; // RL5 RL14
      OFS_POLL: rmux = {poll_r[7], request_pending_bit_r, poll_r[5:0]}; // RL16 RL17
      OFS_ADDR: rmux = {2'b00, serial_poll_active_bit_r, addr_listener_primary_addressed, addr_talker_primary_addressed, addr_listen, addr_talk, second_address_match_bit_r};
      OFS_DEVA: rmux = {1'b0, adr0_r};
      OFS_DEVB: rmux = {eoi_r, adr1_r}; // RL25
      OFS_CORE: rmux = CORE_CONST; // RL26
      default: rmux = 8'h00;
    endcase
  end

  // ****************************************
  // State registers
  // ****************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      din_r <= RST_BYTE;
      eoi_r <= 1'b0;
    end else if (rx_strobe) begin
      din_r <= rx_byte; // RL1
      eoi_r <= rx_eoi; // RL25
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      flag1_r <= RST_BYTE;
      flag2_r <= RST_BYTE;
      lok_d_r <= 1'b0;
      rem_d_r <= 1'b0;
      ads_d_r <= 4'h0;
    end else begin
      flag1_r <= flag1_nxt;
      flag2_r <= flag2_nxt;
      lok_d_r <= rl_lock;
      rem_d_r <= rl_remote;
      ads_d_r <= ads_now;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mask1_r <= RST_BYTE;
      mask2_r <= RST_BYTE;
      amode_r <= RST_BYTE;
      eos_r <= RST_BYTE;
    end else begin
      if (wr_mask1) mask1_r <= reg_wdata; // RL4
      if (wr_mask2) mask2_r <= reg_wdata; // RL15
      if (wr_mode) amode_r <= reg_wdata; // RL18
      if (wr_eos) eos_r <= reg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      adr0_r <= RST_DEVA;
      adr1_r <= RST_DEVA;
    end else if (wr_adr) begin
      if (reg_wdata[B_ARS]) adr1_r <= reg_wdata[6:0]; // RL23
      else adr0_r <= reg_wdata[6:0]; // RL23
    end
  end

  // Service bit is dropped by the poll itself
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      poll_r <= RST_BYTE;
      request_pending_bit_r <= 1'b0;
    end else begin
      if (wr_poll) poll_r <= reg_wdata; // RL16
      else if (poll_active) poll_r[B_RSV] <= 1'b0; // RL16
      if (rsv_rise) request_pending_bit_r <= 1'b1; // RL17
      else if (poll_ack) request_pending_bit_r <= 1'b0; // RL17
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      serial_poll_active_bit_r <= 1'b0;
      second_address_match_bit_r <= 1'b0;
      hold_r <= 1'b0;
      hold_unk_r <= 1'b0;
      unk_prev_r <= 1'b0;
    end else begin
      serial_poll_active_bit_r <= serial_poll_active_bit_nxt;
      second_address_match_bit_r <= second_address_match_bit_nxt;
      if (cmd_unknown) unk_prev_r <= 1'b1; // RL6
      else if (prim_cmd) unk_prev_r <= 1'b0; // RL6
      // Not-valid only frees a hold taken for a secondary address
      if (ev1[B_UNK] || ev1[B_SEC]) begin
        hold_r <= 1'b1; // RL6 RL7
        hold_unk_r <= ev1[B_UNK];
      end else if (cmd_valid || (cmd_not_valid && !hold_unk_r)) begin
        hold_r <= 1'b0; // RL6 RL7
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= RST_BYTE;
      irq_r <= 1'b0;
      dma_r <= 1'b0;
      srq_r <= 1'b0;
    end else begin
      rdata_r <= reg_rd ? rmux : rdata_r;
      irq_r <= irq_nxt;
      dma_r <= dma_nxt;
      srq_r <= srq_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata = rdata_r;
  assign host_irq = irq_r;
  assign dma_req = dma_r;
  assign rx_holdoff = hold_r;
  assign srq_assert = srq_r;
  assign poll_byte = poll_r;
  // Only-modes leave the address registers unused downstream
  assign talk_only = amode_r[B_TON]; // RL18
  assign listen_only = amode_r[B_LON]; // RL18
  assign mode_code = amode_r[1:0]; // RL19 RL20 RL21
  assign dev_addr0 = adr0_r; // RL24
  assign dev_addr1 = adr1_r; // RL24
endmodule // gtlr_regs

`default_nettype wire

/* File: test/gtlr_regs_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port checker
// ****************************************
module gtlr_regs_chk
  import gtlr_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic cmd_unknown,
  input wire logic cmd_valid,
  input wire logic unknown_command_trap_enable,
  input wire logic poll_active,
  input wire logic talk_only,
  input wire logic listen_only,
  input wire logic [1:0] mode_code,
  input wire logic [6:0] dev_addr0,
  input wire logic [6:0] dev_addr1,
  input wire logic srq_assert,
  input wire logic rx_holdoff
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence rsv_wr;
    reg_wr && reg_addr == OFS_POLL && reg_wdata[B_RSV];
  endsequence
  sequence poll_span;
    poll_active [*3];
  endsequence
  core_read_a: assert property (
    reg_rd && reg_addr == OFS_CORE |=> reg_rdata == CORE_CONST)
    else $error("core constant read wrong");
  read_hold_a: assert property (
    !reg_rd |=> $stable(reg_rdata)) else $error("read data moved without a read");
  mode_load_a: assert property (
    reg_wr && reg_addr == OFS_ADDR |=>
    {talk_only, listen_only, 4'h0, mode_code} == ($past(reg_wdata) & 8'hc3))
    else $error("mode bits not loaded");
  addr_first_a: assert property (
    reg_wr && reg_addr == OFS_DEVA && !reg_wdata[B_ARS] |=>
    {1'b0, dev_addr0} == ($past(reg_wdata) & 8'h7f))
    else $error("first address not loaded");
  addr_second_a: assert property (
    reg_wr && reg_addr == OFS_DEVA && reg_wdata[B_ARS] |=>
    {1'b0, dev_addr1} == ($past(reg_wdata) & 8'h7f))
    else $error("second address not loaded");
  srq_raise_a: assert property (
    rsv_wr ##1 !poll_active [*2] |-> srq_assert) else $error("service request not raised");
  srq_poll_a: assert property (
    poll_span |-> !srq_assert) else $error("service request during poll");
  tx_hold_a: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte)) else $error("output byte dropped");
  trap_hold_a: assert property (
    cmd_unknown && unknown_command_trap_enable |-> ##[1:2] rx_holdoff)
    else $error("no handshake hold on unknown command");
  trap_free_a: assert property (
    cmd_valid |-> ##[1:2] !rx_holdoff) else $error("handshake hold not released");
endmodule // gtlr_regs_chk
bind gtlr_regs gtlr_regs_chk chk (.mclk, .nrst, .reg_addr, .reg_rd, .reg_wr, .reg_wdata,
  .reg_rdata, .tx_byte, .tx_valid, .tx_ready, .cmd_unknown, .cmd_valid,
  .unknown_command_trap_enable, .poll_active, .talk_only, .listen_only, .mode_code,
  .dev_addr0, .dev_addr1, .srq_assert, .rx_holdoff);
`default_nettype wire

/* File: test/gtlr_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Far side: handshake partner
// ****************************************
module gtlr_bus_model (
  input wire logic mclk,
  input wire logic stall,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output logic tx_ready,
  output logic [7:0] rx_byte,
  output logic rx_eoi,
  output logic rx_strobe
);
  logic [7:0] got[$];
  initial begin
    tx_ready = 0;
    rx_byte = 8'h00;
    rx_eoi = 0;
    rx_strobe = 0;
  end
  // Every other cycle at best, so the bench can see a slow acceptor
  always @(posedge mclk) begin
    if (tx_valid && tx_ready) got.push_back(tx_byte);
    tx_ready <= #1 tx_valid && !stall && !tx_ready;
  end
  // Lines show the inverse once released so stale data never matches
  task automatic send(input logic [7:0] b, input logic e);
    rx_byte = b;
    rx_eoi = e;
    rx_strobe = 1;
    @(posedge mclk) #1;
    rx_strobe = 0;
    rx_byte = ~b;
    rx_eoi = ~e;
  endtask
endmodule // gtlr_bus_model
`default_nettype wire

/* File: test/gtlr_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module gtlr_regs_tb;
  import gtlr_pkg::*;
  logic mclk = 0, nrst = 0, reg_rd = 0, reg_wr = 0, stall = 0, rx_eoi, rx_strobe;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, rx_byte, tx_byte, poll_byte, v;
  logic host_irq, dma_req, rx_holdoff, tx_valid, tx_ready, talk_only, listen_only, srq_assert;
  logic tx_no_listener = 0, source_idle = 0, cmd_unknown = 0, cmd_secondary = 0;
  logic cmd_valid = 0, cmd_not_valid = 0, msg_get = 0, msg_dcl = 0, msg_sdc = 0;
  logic msg_spe = 0, msg_spd = 0, msg_ifc = 0, poll_active = 0, poll_ack = 0, lads = 0;
  logic rl_lock = 0, rl_remote = 0, addr_talk = 0, addr_listen = 0, addr_talker_primary_addressed = 0;
  logic addr_listener_primary_addressed = 0, addr_cic = 0, addr_first = 0, addr_second = 0;
  logic unknown_command_trap_enable = 0, continuous_mode = 0, eos_enable = 0, eos_8bit = 0;
  logic [1:0] mode_code;
  logic [6:0] dev_addr0, dev_addr1;
  int err_total = 0, total_checks = 0;
  localparam logic [7:0] OREQ = 8'h1 << B_OREQ;
  gtlr_regs #(.FDEPTH(FIFO_DEPTH)) uut (.mclk, .nrst, .reg_addr, .reg_rd, .reg_wr,
    .reg_wdata, .reg_rdata, .host_irq, .dma_req, .rx_byte, .rx_eoi, .rx_strobe,
    .rx_holdoff, .tx_byte, .tx_valid, .tx_ready, .tx_no_listener, .source_idle,
    .cmd_unknown, .cmd_secondary, .cmd_valid, .cmd_not_valid, .msg_get, .msg_dcl,
    .msg_sdc, .msg_spe, .msg_spd, .msg_ifc, .poll_active, .poll_ack, .lads, .rl_lock,
    .rl_remote, .addr_talk, .addr_listen, .addr_talker_primary_addressed, .addr_listener_primary_addressed, .addr_cic, .addr_first,
    .addr_second, .unknown_command_trap_enable, .continuous_mode, .eos_enable, .eos_8bit,
    .talk_only, .listen_only, .mode_code, .dev_addr0, .dev_addr1, .srq_assert, .poll_byte);
  gtlr_bus_model bus (.mclk, .stall, .tx_valid, .tx_byte, .tx_ready, .rx_byte, .rx_eoi,
    .rx_strobe);
  initial begin
    forever #50 mclk = ~mclk;
  end
  // ****************************************
  // Bus cycles and comparison
  // ****************************************
  task automatic tick;
    @(posedge mclk) #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    tick;
    reg_wr = 0;
    tick;
  endtask
  task automatic rd(input logic [3:0] a);
    reg_addr = a;
    reg_rd = 1;
    tick;
    reg_rd = 0;
    v = reg_rdata;
    tick;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_rx;
    bus.send(8'h5a, 1);
    rd(OFS_DATA); chk(v, 8'h5a);
    rd(OFS_DEVB); chk(v & 8'h80, 8'h80);
    rd(OFS_EVT1); chk(v, 8'h11 | OREQ);
    rd(OFS_EVT1); chk(v, OREQ);
    continuous_mode = 1;
    bus.send(8'h33, 0);
    rd(OFS_EVT1); chk(v, OREQ);
    continuous_mode = 0;
    wr(OFS_DEVB, 8'h0a);
    eos_enable = 1;
    bus.send(8'h0a, 0);
    rd(OFS_EVT1); chk(v, 8'h11 | OREQ);
    wr(OFS_EVT2, 8'h1 << B_DMA_IN_CONTROL);
    bus.send(8'h44, 0);
    tick; chk({7'h0, dma_req}, 8'h01);
    rd(OFS_EVT1); chk(v, 8'h01 | OREQ);
    tick; chk({7'h0, dma_req}, 8'h00);
    wr(OFS_EVT2, 8'h00);
    $display("rx done");
  endtask
  task automatic t_tx;
    stall = 1;
    wr(OFS_EVT2, 8'h1 << B_DMA_OUT_CONTROL);
    tick; chk({7'h0, dma_req}, 8'h01);
    for (int i = 0; i < 5; i++) wr(OFS_DATA, 8'h80 + 8'(i));
    tick; chk({7'h0, dma_req}, 8'h00);
    chk(tx_byte, 8'h80);
    tx_no_listener = 1;
    stall = 0;
    repeat (30) tick;
    tx_no_listener = 0;
    chk(8'(bus.got.size()), 8'h04);
    for (int i = 0; i < 4; i++) chk(bus.got[i], 8'h80 + 8'(i));
    rd(OFS_EVT1); chk(v, 8'h04 | OREQ);
    wr(OFS_EVT2, 8'h00);
    source_idle = 1;
    wr(OFS_DATA, 8'h11);
    source_idle = 0;
    rd(OFS_EVT1); chk(v, 8'h04 | OREQ);
    $display("tx done");
  endtask
  task automatic t_irq;
    wr(OFS_EVT1, 8'h1 << B_TRG);
    msg_get = 1; tick; msg_get = 0; tick;
    chk({7'h0, host_irq}, 8'h00);
    lads = 1;
    msg_get = 1; tick; msg_get = 0; tick; tick;
    chk({7'h0, host_irq}, 8'h01);
    rd(OFS_EVT2); chk(v, 8'h80);
    rd(OFS_EVT1); chk(v, 8'h20 | OREQ);
    tick; tick; chk({7'h0, host_irq}, 8'h00);
    msg_sdc = 1; tick; msg_sdc = 0;
    rd(OFS_EVT1); chk(v, 8'h08 | OREQ);
    lads = 0;
    msg_dcl = 1; tick; msg_dcl = 0;
    rd(OFS_EVT1); chk(v, 8'h08 | OREQ);
    wr(OFS_EVT1, 8'h00);
    $display("irq done");
  endtask
  task automatic t_poll;
    wr(OFS_POLL, 8'hc5);
    tick; tick; chk({7'h0, srq_assert}, 8'h01);
    rd(OFS_POLL); chk(v, 8'hc5);
    poll_active = 1;
    tick; tick; tick; chk({7'h0, srq_assert}, 8'h00);
    poll_ack = 1; tick; poll_ack = 0; poll_active = 0;
    rd(OFS_POLL); chk(v, 8'h85);
    chk(poll_byte, 8'h85);
    $display("poll done");
  endtask
  task automatic t_addr;
    logic [7:0] m[5] = '{8'h80, 8'h40, 8'h01, 8'h02, 8'h03};
    foreach (m[i]) begin
      wr(OFS_ADDR, m[i]);
      chk({talk_only, listen_only, 4'h0, mode_code}, m[i]);
    end
    wr(OFS_DEVA, 8'h25);
    wr(OFS_DEVA, 8'h9a);
    rd(OFS_DEVA); chk(v, 8'h25);
    rd(OFS_DEVB); chk(v, 8'h1a);
    $display("addr done");
  endtask
  task automatic t_trap;
    unknown_command_trap_enable = 1;
    cmd_unknown = 1; tick; cmd_unknown = 0; tick;
    chk({7'h0, rx_holdoff}, 8'h01);
    rd(OFS_EVT1); chk(v, 8'h80 | OREQ);
    cmd_valid = 1; tick; cmd_valid = 0; tick;
    chk({7'h0, rx_holdoff}, 8'h00);
    msg_spd = 1; tick; msg_spd = 0;
    cmd_secondary = 1; tick; cmd_secondary = 0; tick;
    chk({7'h0, rx_holdoff}, 8'h01);
    rd(OFS_EVT1); chk(v, 8'h40 | OREQ);
    cmd_not_valid = 1; tick; cmd_not_valid = 0; tick;
    chk({7'h0, rx_holdoff}, 8'h00);
    cmd_unknown = 1; tick; cmd_unknown = 0;
    rd(OFS_EVT1);
    cmd_secondary = 1; tick; cmd_secondary = 0;
    rd(OFS_EVT1); chk(v, 8'h80 | OREQ);
    cmd_not_valid = 1; tick; cmd_not_valid = 0; tick;
    chk({7'h0, rx_holdoff}, 8'h01);
    cmd_valid = 1; tick; cmd_valid = 0;
    msg_spd = 1; tick; msg_spd = 0; tick;
    chk({7'h0, rx_holdoff}, 8'h00);
    wr(OFS_ADDR, 8'h01);
    cmd_secondary = 1; tick; cmd_secondary = 0; tick;
    rd(OFS_EVT1); chk(v, OREQ);
    $display("trap done");
  endtask
  task automatic t_stat;
    {rl_lock, rl_remote, addr_talk, addr_listen, addr_talker_primary_addressed, addr_listener_primary_addressed} = 6'h3f;
    msg_spe = 1; addr_second = 1; tick; msg_spe = 0; addr_second = 0; tick;
    rd(OFS_EVT2); chk(v, 8'h37);
    rd(OFS_EVT2); chk(v, 8'h30);
    rd(OFS_ADDR); chk(v, 8'h3f);
    msg_ifc = 1; addr_first = 1; tick; msg_ifc = 0; addr_first = 0; tick;
    rd(OFS_ADDR); chk(v, 8'h1e);
    rd(OFS_CORE); chk(v, CORE_CONST);
    wr(OFS_CORE, 8'hff);
    rd(OFS_CORE); chk(v, CORE_CONST);
    $display("status done");
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    #1 nrst = 1;
    tick;
    t_rx;
    t_tx;
    t_irq;
    t_poll;
    t_addr;
    t_trap;
    t_stat;
    test_done;
  end
  initial begin
    repeat (5000) @(posedge mclk);
    err_total++;
    test_done;
  end
endmodule // gtlr_regs_tb
`default_nettype wire
